// ==== core/pin_remap_cfg.svh ====
// Offsets, field positions, reset values and sizes of the pin remapper
// How it works
// - Each output map register holds odd pin in bits 12-8, even in 4-0.
// - Selector value n (1-18) routes peripheral output function n onto that pin; 0 and 19-31 leave it undriven.
// - Bits 15-13 and 7-5 of output map registers always read zero.
// - Output selector bits are read/write and clear to zero at reset.
// - Small package: map registers for pins 16-25 absent, read zero.
// - SPI2 select input comes from pin chosen by bits 4-0; 15-5 read zero.
`ifndef PIN_REMAP_CFG_SVH
`define PIN_REMAP_CFG_SVH

// ============================================================
// Bus geometry
`define PRM_ADDR_W          4
`define PRM_DATA_W          16

// ============================================================
// Register indices
`define PRM_IDX_OUT_FIRST   4'h0
`define PRM_IDX_OUT_LAST    4'hC
`define PRM_IDX_SPI2_SEL    4'hD

// ============================================================
// Field positions
`define PRM_SEL_W           5
`define PRM_EVEN_LSB        0
`define PRM_ODD_LSB         8
`define PRM_SPI2_LSB        0

// ============================================================
// Reset values
`define PRM_OUT_RST         5'h00
`define PRM_SPI2_RST        5'h1F

// ============================================================
// Sizes
`define PRM_PIN_COUNT       26
`define PRM_PAIR_COUNT      13
`define PRM_SMALL_PIN_LAST  15
`define PRM_IN_ONLY_COUNT   6
`define PRM_FUNC_LAST       18

`endif

// ==== core/pin_remap_pkg.sv ====
// Types shared by the pin remapper
package pin_remap_pkg;
`include "pin_remap_cfg.svh"

  typedef logic [`PRM_SEL_W-1:0]  sel_t;
  typedef logic [`PRM_DATA_W-1:0] word_t;
  typedef logic [`PRM_ADDR_W-1:0] addr_t;
  typedef logic [`PRM_FUNC_LAST:0] func_vec_t;

  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_WRITE = 2'b01,
    ACC_READ  = 2'b10
  } access_t;

endpackage : pin_remap_pkg

// ==== core/pin_out_slot.sv ====
// One remappable pin: picks a peripheral output function by selector
`timescale 1ns/1ps
`include "pin_remap_cfg.svh"
module pin_out_slot
  import pin_remap_pkg::*;
(
  // Clock and reset
  input  wire logic      i_mclk,
  input  wire logic      i_nrst,
  // Selector and peripheral outputs
  input  wire sel_t      i_sel,
  input  wire func_vec_t i_func_data,
  // Pin side
  output logic           o_pin_data,
  output logic           o_pin_drive
);

  logic valid_sel;

  // ============================================================
  // Function select
  assign valid_sel = (i_sel != '0) &&
                     (i_sel <= sel_t'(`PRM_FUNC_LAST));

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pin_data  <= 1'b0;
      o_pin_drive <= 1'b0;
    end else if (valid_sel) begin
      o_pin_data  <= i_func_data[i_sel];
      o_pin_drive <= 1'b1;
    end else begin
      o_pin_data  <= 1'b0;
      o_pin_drive <= 1'b0;
    end
  end

endmodule : pin_out_slot

// ==== core/pin_remap_out.sv ====
// Remappable pin output selector with SPI2 slave-select input routing
`timescale 1ns/1ps
`include "pin_remap_cfg.svh"
module pin_remap_out
  import pin_remap_pkg::*;
(
  // Clock and reset
  input  wire logic                         i_mclk,
  input  wire logic                         i_nrst,
  // Package strap, high on the small package
  input  wire logic                         i_pkg_small,
  // Register port
  input  wire addr_t                        i_addr,
  input  wire word_t                        i_wdata,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  output word_t                             o_rdata,
  // Peripheral output functions, bit 0 unused
  input  wire func_vec_t                    i_func_data,
  // Remappable pins
  output logic [`PRM_PIN_COUNT-1:0]         o_pin_data,
  output logic [`PRM_PIN_COUNT-1:0]         o_pin_drive,
  input  wire logic [`PRM_PIN_COUNT-1:0]    i_io_pin,
  input  wire logic [`PRM_IN_ONLY_COUNT-1:0] i_in_only_pin,
  // SPI2 slave-select input
  output logic                              o_spi2_slave_select_input
);

  sel_t                          pin_sel_reg [`PRM_PIN_COUNT];
  sel_t                          spi2_sel_reg;
  logic                          small_reg;
  logic                          strap_done_reg;
  word_t                         rdata_next;
  access_t                       access;
  logic                          pair_hit;
  logic                          pair_absent;
  logic [3:0]                    pair_idx;
  logic [`PRM_PIN_COUNT+`PRM_IN_ONLY_COUNT-1:0] select_pins;
  func_vec_t                     func_vec;

  // ============================================================
  // Access decode
  always_comb begin
    if (i_wr) begin
      access = ACC_WRITE;
    end else if (i_rd) begin
      access = ACC_READ;
    end else begin
      access = ACC_IDLE;
    end
  end

  assign pair_idx    = i_addr;
  assign pair_hit    = (i_addr <= `PRM_IDX_OUT_LAST);
  // Pairs 8..12 carry pins 16..25
  // Strap taken straight from the pin until it has been caught
  assign pair_absent = (strap_done_reg ? small_reg : i_pkg_small) &&
                       (i_addr > addr_t'(`PRM_SMALL_PIN_LAST / 2));

  // ============================================================
  // Package strap, caught after reset release
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      small_reg      <= 1'b0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      small_reg      <= i_pkg_small;
      strap_done_reg <= 1'b1;
    end
  end

  // ============================================================
  // Output selector storage
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int p = 0; p < `PRM_PIN_COUNT; p++) begin
        pin_sel_reg[p] <= `PRM_OUT_RST;
      end
    end else begin
      if (access == ACC_WRITE && pair_hit && !pair_absent) begin
        pin_sel_reg[{pair_idx, 1'b0}] <=
          i_wdata[`PRM_EVEN_LSB +: `PRM_SEL_W];
        pin_sel_reg[{pair_idx, 1'b1}] <=
          i_wdata[`PRM_ODD_LSB +: `PRM_SEL_W];
      end
      if (small_reg) begin
        for (int p = `PRM_SMALL_PIN_LAST + 1; p < `PRM_PIN_COUNT; p++) begin
          pin_sel_reg[p] <= `PRM_OUT_RST;
        end
      end
    end
  end

  // ============================================================
  // SPI2 select storage
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      spi2_sel_reg <= `PRM_SPI2_RST;
    end else if (access == ACC_WRITE && i_addr == `PRM_IDX_SPI2_SEL) begin
      spi2_sel_reg <= i_wdata[`PRM_SPI2_LSB +: `PRM_SEL_W];
    end
  end

  // ============================================================
  // Read path
  always_comb begin
    rdata_next = '0;
    if (pair_hit && !pair_absent) begin
      rdata_next[`PRM_EVEN_LSB +: `PRM_SEL_W] =
        pin_sel_reg[{pair_idx, 1'b0}];
      rdata_next[`PRM_ODD_LSB +: `PRM_SEL_W] =
        pin_sel_reg[{pair_idx, 1'b1}];
    end else if (i_addr == `PRM_IDX_SPI2_SEL) begin
      rdata_next[`PRM_SPI2_LSB +: `PRM_SEL_W] = spi2_sel_reg;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= '0;
    end else if (access == ACC_READ) begin
      o_rdata <= rdata_next;
    end else begin
      o_rdata <= '0;
    end
  end

  // ============================================================
  // Output pin routing
  assign func_vec = {i_func_data[`PRM_FUNC_LAST:1], 1'b0};

  for (genvar g = 0; g < `PRM_PIN_COUNT; g++) begin : g_slot
    pin_out_slot u_slot (
      .i_mclk      (i_mclk),
      .i_nrst      (i_nrst),
      .i_sel       (pin_sel_reg[g]),
      .i_func_data (func_vec),
      .o_pin_data  (o_pin_data[g]),
      .o_pin_drive (o_pin_drive[g])
    );
  end

  // ============================================================
  // SPI2 slave-select input routing
  assign select_pins = {i_in_only_pin, i_io_pin};

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_spi2_slave_select_input <= 1'b1;
    end else begin
      o_spi2_slave_select_input <= select_pins[spi2_sel_reg];
    end
  end

endmodule : pin_remap_out

// ==== tb/periph_pin_model.sv ====
// Model of peripheral outputs and remappable pin levels
`timescale 1ns/1ps
module periph_pin_model
  import pin_remap_pkg::*;
(
  // Clock and reset
  input  wire logic   i_mclk,
  input  wire logic   i_nrst,
  // Levels seen by the remapper
  output func_vec_t   o_func,
  output logic [25:0] o_io,
  output logic [5:0]  o_in_only
);
  // =======
  // Levels change every cycle so stale routing shows
  logic [31:0] mix_reg;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) mix_reg <= 32'h00000001;
    else mix_reg <= mix_reg * 32'h0019660D + 32'h3C6EF35F;
  end
  assign o_func    = mix_reg[31:13];
  assign o_io      = mix_reg[25:0];
  assign o_in_only = mix_reg[31:26];
endmodule : periph_pin_model

// ==== tb/pin_remap_checker.sv ====
// Port assertions for the pin remapper
`timescale 1ns/1ps
module pin_remap_checker
  import pin_remap_pkg::*;
(
  // Watched ports
  input wire logic        i_mclk,
  input wire logic        i_nrst,
  input wire logic        i_pkg_small,
  input wire addr_t       i_addr,
  input wire word_t       i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire word_t       o_rdata,
  input wire func_vec_t   i_func_data,
  input wire logic [25:0] o_pin_data,
  input wire logic [25:0] o_pin_drive
);
  // =======
  // Properties
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  chk_gap_bits: assert property (
    o_rdata[15:13] == 3'h0 && o_rdata[7:5] == 3'h0)
    else $error("gap bits set");
  chk_rw_field: assert property (
    !i_pkg_small && i_wr && i_addr <= 4'hC
    ##1 i_rd && $stable(i_addr)
    |=> o_rdata == ($past(i_wdata, 2) & 16'h1F1F))
    else $error("read back differs");
  chk_route_func: assert property (
    i_wr && i_addr == 4'h0 && i_wdata[4:0] == 5'h05 ##1 !i_wr
    |=> o_pin_drive[0] && o_pin_data[0] == $past(i_func_data[5]))
    else $error("function not routed");
  chk_zero_free: assert property (
    i_wr && i_addr == 4'h0 && i_wdata[4:0] == 5'h00 ##1 !i_wr
    |=> !o_pin_drive[0])
    else $error("pin driven by zero selector");
  chk_small_read: assert property (
    i_pkg_small && i_rd && i_addr >= 4'h8 && i_addr <= 4'hC
    |=> o_rdata == 16'h0000)
    else $error("absent register reads nonzero");
  chk_small_pins: assert property (
    i_pkg_small |-> o_pin_drive[25:16] == 10'h000)
    else $error("absent pin driven");
  chk_spi2_bits: assert property (
    i_rd && i_addr == 4'hD |=> o_rdata[15:5] == 11'h000)
    else $error("select register high bits set");
endmodule : pin_remap_checker

bind pin_remap_out pin_remap_checker chk_u (.i_mclk(i_mclk), .i_nrst(i_nrst),
  .i_pkg_small(i_pkg_small), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_func_data(i_func_data),
  .o_pin_data(o_pin_data), .o_pin_drive(o_pin_drive));

// ==== tb/remappable_pin_output_select_bench.sv ====
// Self-checking bench for the pin remapper
`timescale 1ns/1ps
module remappable_pin_output_select_bench;
  import pin_remap_pkg::*;
  // =======
  // Signals and instances
  logic i_mclk, i_nrst, i_pkg_small, i_wr, i_rd, o_ss;
  addr_t i_addr;
  word_t i_wdata, o_rdata, rv;
  func_vec_t fd_w, fd;
  logic [25:0] o_pin_data, o_pin_drive, io_w;
  logic [5:0] ino_w;
  logic [31:0] pv;
  int fails, cmp_count, cyc;
  pin_remap_out dut_u (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_pkg_small(i_pkg_small), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_func_data(fd_w),
    .o_pin_data(o_pin_data), .o_pin_drive(o_pin_drive), .i_io_pin(io_w),
    .i_in_only_pin(ino_w), .o_spi2_slave_select_input(o_ss));
  periph_pin_model pm_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .o_func(fd_w),
    .o_io(io_w), .o_in_only(ino_w));
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  // Levels the design sampled at the last edge
  always @(posedge i_mclk) fd <= fd_w;
  always @(posedge i_mclk) pv <= {ino_w, io_w};
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rst(logic s);
    i_nrst <= 1'b0;
    i_pkg_small <= s;
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1'b1;
    repeat (2) @(posedge i_mclk);
  endtask : rst
  // Write, then optionally read the same place back to back
  task automatic wr(addr_t a, word_t d, logic back);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    i_rd <= back;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask : wr
  // Single read, data taken in the cycle after the strobe
  task automatic rd(addr_t a);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask : rd
  // =======
  // Scenarios
  task automatic t_regs();
    for (int a = 0; a < 16; a++) begin
      logic [31:0] ev;
      ev = a < 13 ? 32'h1A05 : (a == 13 ? 32'h0005 : 32'h0000);
      wr(4'(a), 16'h9A65, 1'b1);
      chk("fields", rv, ev);
    end
  endtask : t_regs
  task automatic t_route();
    for (int n = 0; n < 26; n++) begin
      wr(4'(n / 2), n[0] ? {3'h0, n[4:0], 8'h00} : {11'h000, n[4:0]}, 1'b0);
      #1 chk("drive", o_pin_drive[n], n > 0 && n < 19);
      if (n > 0 && n < 19) chk("data", o_pin_data[n], fd[n]);
    end
  endtask : t_route
  task automatic t_spi2();
    for (int s = 0; s < 32; s++) begin
      wr(4'hD, {11'h000, s[4:0]}, 1'b0);
      #1 chk("spi2", o_ss, pv[s]);
    end
  endtask : t_spi2
  task automatic t_small();
    rst(1'b1);
    wr(4'h8, 16'h0005, 1'b1);
    chk("absent", rv, 32'h0);
    chk("absent pin", o_pin_drive[16], 1'b0);
    wr(4'h0, 16'h0005, 1'b1);
    chk("present", rv, 32'h0005);
  endtask : t_small
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    {i_nrst, i_pkg_small, i_wr, i_rd, i_addr, i_wdata} = '0;
    {fails, cmp_count, cyc} = '0;
    rst(1'b0);
    rd(4'h0);
    chk("reset pair", rv, 32'h0);
    rd(4'hD);
    chk("reset select", rv, 32'h001F);
    wr(4'h0, 16'h1F1F, 1'b0);
    wr(4'hD, 16'h0000, 1'b0);
    rst(1'b0);
    rd(4'h0);
    chk("mid reset pair", rv, 32'h0);
    rd(4'hD);
    chk("mid reset select", rv, 32'h001F);
    t_regs();
    t_route();
    t_spi2();
    t_small();
    report_and_stop();
  end
endmodule : remappable_pin_output_select_bench
